// ==== rtl/mafe_defs.svh ====
`ifndef MAFE_DEFS_SVH
`define MAFE_DEFS_SVH

// ********************************
// Bit clock and frame timing
// ********************************
`define MAFE_SCLK_DIV 18
`define MAFE_FRAME_BITS_N 256
`define MAFE_DIV_LAST 5'h11
`define MAFE_DIV_FALL 5'h08
`define MAFE_DIV_ZERO 5'h00
`define MAFE_FRAME_BITS 9'h100
`define MAFE_FRAME_LAST 9'h0ff
`define MAFE_BCNT_ZERO 9'h000
`define MAFE_SLOT_ZERO 5'h00
`define MAFE_SLOT_LAST 5'h0f
`define MAFE_RD_SLOT 5'h07
`define MAFE_POS_HALF 9'h080
`define MAFE_POS_QUARTER 9'h040
`define MAFE_CHAIN_LAST 5'h1f
`define MAFE_GATE_LOAD 6'h1f
`define MAFE_GATE_ZERO 6'h00
`define MAFE_WORD_ZERO 16'h0000
`define MAFE_WORD_W 16
`define MAFE_FIFO_DEPTH 16

// ********************************
// Register indexes and fields
// ********************************
`define MAFE_ADDR_HI_ZERO 3'h0
`define MAFE_R_CTRL 4'h0
`define MAFE_R_TEST 4'h1
`define MAFE_R_GDIR 4'h3
`define MAFE_R_REV 4'h6
`define MAFE_R_PLL_FIRST 4'h8
`define MAFE_R_PLL_LOCK 4'he
`define MAFE_B_HC 0
`define MAFE_B_CONTROL_FRAME_POSITION_BIT 1
`define MAFE_B_CKOUT 3
`define MAFE_B_DELAYED_SYNC_ENABLE 3
`define MAFE_B_FRONT_END_ENABLE 7
`define MAFE_B_FRCVCO 7
`define MAFE_B_PWDN 6
`define MAFE_B_LOCK 5
`define MAFE_RO_REV 8'hf0
`define MAFE_RO_LOCK 8'h20
`define MAFE_RO_NONE 8'h00

// ********************************
// Register reset values
// ********************************
`define MAFE_RST_ZERO 8'h00
`define MAFE_RST_CTRL 8'h08
`define MAFE_RST_GPIO 8'hff
`define MAFE_RST_PRST 8'h0a
`define MAFE_RST_KVCO 8'h22
`define MAFE_RST_PDIV 8'h12
`define MAFE_RST_XTAL 8'hc0
`define MAFE_RST_REV_LOW 4'h0

`endif

// ==== rtl/mafe_pkg.sv ====
package mafe_pkg;

  typedef enum logic [2:0] {
    MAFE_PH_IDLE = 3'b001,
    MAFE_PH_DATA = 3'b010,
    MAFE_PH_CTRL = 3'b100
  } mafe_phase_t;

  typedef struct packed {
    logic rw;
    logic [6:0] addr;
    logic [7:0] data;
  } mafe_ctl_word_t;

  typedef struct packed {
    logic slave_mode;
    logic early_sync;
    logic front_end_enable;
    logic hardware_control_bit;
    logic control_frame_position_bit;
    logic clock_output_enable;
    logic delayed_sync_enable;
    logic use_pll_clock;
  } mafe_cfg_t;

  typedef logic [14:0][7:0] mafe_regs_t;

endpackage

// ==== rtl/mafe_fifo.sv ====
module mafe_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap naturally, so DEPTH must be a power of two
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic room_q, room_d, empty_q, empty_d;
  logic push, pop;

  assign push = in_valid && room_q;
  assign pop = out_ready && !empty_q;

  always_comb begin
    wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
    case ({push, pop})
      2'b10: cnt_d = (AW+1)'(cnt_q + 1'b1);
      2'b01: cnt_d = (AW+1)'(cnt_q - 1'b1);
      default: cnt_d = cnt_q;
    endcase
    room_d = (cnt_d != (AW+1)'(DEPTH));
    empty_d = (cnt_d == '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      room_q <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      room_q <= room_d;
      empty_q <= empty_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  assign in_ready = room_q;
  assign out_valid = !empty_q;
  assign out_data = mem[rp_q];

endmodule

// ==== rtl/mafe_serial_port.sv ====
// How it works
// R1: master bit clock is system clock over eighteen
// R2: one frame sync per 256 bit clocks
// R3: crystal after reset; PLL only when forced
// R4: host forces PLL two frames after programming
// R5: host returns to crystal before PLL reprogramming
// R6: type pin at reset selects early or late
// R7: sixteen bits each way, MSB first
// R8: software mode: bit 0 requests control frame
// R9: hardware mode: control frame after every data frame
// R10: control word is flag, address, data
// R11: write flag stores byte, returns zeros
// R12: read flag returns register in low byte
// R13: at most one control frame between data
// R14: unimplemented writes ignored, reads arbitrary
// R15: position bit picks half or quarter point
// R16: gating pin low gives 32 clocks per sync
// R17: drive after rising, sample on falling edge
// R18: clock pin low at reset means slave
// R19: slave master gives 96 to 256 clocks
// R20: host enables daisy chain in fixed order
// R21: chain slots of 16 bits, late sync
// R22: slave and chain use hardware control only
// R23: delayed sync driven only when enabled
`include "mafe_defs.svh"

module mafe_serial_port
  import mafe_pkg::*;
#(
  parameter logic [3:0] REV_ID = 4'h5,
  parameter int FRAME_CYCLES = `MAFE_SCLK_DIV * `MAFE_FRAME_BITS_N
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic frame_type_pin,
  input wire logic bit_clock_gating_pin,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe_n,
  input wire logic fs_in,
  output logic frame_sync_n,
  output logic frame_sync_oe_n,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic delayed_frame_sync,
  output logic delayed_frame_sync_oe_n,
  input wire logic pll_lock,
  input wire logic [15:0] rx_word,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [15:0] tx_word,
  output logic tx_valid,
  output mafe_cfg_t cfg
);

  // ********************************
  // Register file helpers
  // ********************************
  // Revision nibble is arbitrary
  localparam mafe_regs_t REG_RST = {
    `MAFE_RST_ZERO, `MAFE_RST_XTAL, `MAFE_RST_ZERO, `MAFE_RST_PDIV,
    `MAFE_RST_KVCO, `MAFE_RST_PRST, `MAFE_RST_ZERO, `MAFE_RST_ZERO,
    {REV_ID, `MAFE_RST_REV_LOW}, `MAFE_RST_ZERO, `MAFE_RST_ZERO,
    `MAFE_RST_GPIO, `MAFE_RST_GPIO, `MAFE_RST_ZERO, `MAFE_RST_CTRL};

  function automatic logic is_impl(input logic [6:0] a);
    is_impl = (a[6:4] == `MAFE_ADDR_HI_ZERO) &&
              ((a[3:0] <= `MAFE_R_GDIR) || (a[3:0] == `MAFE_R_REV) ||
               ((a[3:0] >= `MAFE_R_PLL_FIRST) && (a[3:0] <= `MAFE_R_PLL_LOCK)));
  endfunction

  function automatic logic [7:0] ro_mask(input logic [3:0] a);
    if (a == `MAFE_R_REV) ro_mask = `MAFE_RO_REV;
    else if (a == `MAFE_R_PLL_LOCK) ro_mask = `MAFE_RO_LOCK;
    else ro_mask = `MAFE_RO_NONE;
  endfunction

  function automatic logic [7:0] reg_read(input logic [6:0] a, input mafe_regs_t r,
                                          input logic lk);
    logic [7:0] v;
    v = `MAFE_RST_ZERO;
    if (is_impl(a)) begin
      v = r[a[3:0]];
      if (a[3:0] == `MAFE_R_PLL_LOCK) v[`MAFE_B_LOCK] = lk;
    end
    reg_read = v;
  endfunction

  // ********************************
  // State
  // ********************************
  logic strap_q, strap_d, slave_q, slave_d, early_q, early_d;
  logic [4:0] div_q, div_d;
  logic sclk_prev_q, sclk_prev_d, fs_prev_q, fs_prev_d;
  logic [8:0] bcnt_q, bcnt_d, len_q, len_d, pos, nb;
  mafe_phase_t phase_q, phase_d;
  logic [4:0] slot_q, slot_d;
  logic [5:0] gcnt_q, gcnt_d;
  logic [15:0] osh_q, osh_d, ish_q, ish_d, tx_q, tx_d, word, full;
  logic sout_q, sout_d, fs_q, fs_d, ds_q, ds_d, dsoe_q, dsoe_d;
  logic sclk_q, sclk_d, txv_q, txv_d, pend_q, pend_d;
  mafe_regs_t regs_q, regs_d;
  mafe_cfg_t cfg_q, cfg_d;
  mafe_ctl_word_t cw;
  logic [7:0] rdat;
  logic rise, fall, start_data, start_ctrl, fsb, pop, fifo_valid, hc;
  logic [15:0] fifo_data;

  // Slave edges come from the pin, which is taken as synchronous
  assign rise = strap_q && (slave_q ? (sclk_in && !sclk_prev_q)
                                    : (div_q == `MAFE_DIV_LAST));
  assign fall = strap_q && (slave_q ? (!sclk_in && sclk_prev_q)
                                    : (div_q == `MAFE_DIV_FALL));
  assign hc = regs_q[`MAFE_R_TEST][`MAFE_B_HC];
  assign pos = regs_q[`MAFE_R_TEST][`MAFE_B_CONTROL_FRAME_POSITION_BIT] ? (len_q >> 2) : (len_q >> 1);

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    strap_d = 1'b1;
    slave_d = slave_q;
    early_d = early_q;
    if (!strap_q) begin
      slave_d = !sclk_in; // see R18
      early_d = frame_type_pin; // see R6
    end
    div_d = div_q;
    if (!slave_q) begin
      div_d = (div_q == `MAFE_DIV_LAST) ? `MAFE_DIV_ZERO : 5'(div_q + 5'h01); // see R1
    end
    sclk_prev_d = sclk_in;
    fs_prev_d = fs_prev_q;
    bcnt_d = bcnt_q;
    len_d = len_q;
    phase_d = phase_q;
    slot_d = slot_q;
    gcnt_d = gcnt_q;
    osh_d = osh_q;
    ish_d = ish_q;
    sout_d = sout_q;
    fs_d = fs_q;
    ds_d = ds_q;
    sclk_d = sclk_q;
    pend_d = pend_q;
    tx_d = tx_q;
    txv_d = 1'b0;
    regs_d = regs_q;
    nb = bcnt_q;
    word = `MAFE_WORD_ZERO;
    full = `MAFE_WORD_ZERO;
    rdat = `MAFE_RST_ZERO;
    cw = `MAFE_WORD_ZERO;
    start_data = 1'b0;
    start_ctrl = 1'b0;
    fsb = 1'b0;
    pop = 1'b0;
    if (rise) begin
      fs_prev_d = fs_in;
      nb = 9'(bcnt_q + 9'h001);
      if (!slave_q && nb == `MAFE_FRAME_BITS) nb = `MAFE_BCNT_ZERO; // see R2
      if (slave_q && !fs_in && fs_prev_q) begin
        // Slave frame length is measured to place control frames
        len_d = nb;
        nb = `MAFE_BCNT_ZERO;
      end
      bcnt_d = nb;
      start_data = (nb == `MAFE_BCNT_ZERO);
      start_ctrl = !start_data && pend_q && (nb == pos); // see R15
      if (start_data || start_ctrl) begin
        phase_d = start_data ? MAFE_PH_DATA : MAFE_PH_CTRL;
        slot_d = `MAFE_SLOT_ZERO;
        pend_d = 1'b0; // see R13
        pop = start_data && fifo_valid;
        // An empty buffer sends silence rather than stalling the frame
        word = pop ? fifo_data : `MAFE_WORD_ZERO; // see R2
        sout_d = word[15]; // see R7
        osh_d = {word[14:0], 1'b0};
      end else begin
        case (phase_q)
          MAFE_PH_DATA, MAFE_PH_CTRL: begin
            slot_d = 5'(slot_q + 5'h01);
            if (slot_q == `MAFE_CHAIN_LAST) phase_d = MAFE_PH_IDLE;
            sout_d = osh_q[15];
            osh_d = {osh_q[14:0], 1'b0};
            if (phase_q == MAFE_PH_CTRL && slot_q == `MAFE_RD_SLOT) begin
              // Flag and address are complete just before the low byte
              rdat = ish_q[7] ? reg_read(ish_q[6:0], regs_q, pll_lock)
                              : `MAFE_RST_ZERO; // see R11 see R12
              sout_d = rdat[7];
              osh_d = {rdat[6:0], 9'h000};
            end
          end
          MAFE_PH_IDLE: sout_d = 1'b0;
          default: phase_d = MAFE_PH_IDLE;
        endcase
      end
      if (!slave_q) begin
        if (early_q) begin
          fs_d = !((nb == `MAFE_FRAME_LAST) || (pend_q && 9'(nb + 9'h001) == pos)); // see R6
        end else begin
          fs_d = !((phase_d != MAFE_PH_IDLE) && (slot_d <= `MAFE_SLOT_LAST)); // see R6
        end
      end
      // Next device's slot follows ours; its sync is always late type
      ds_d = !((phase_d != MAFE_PH_IDLE) && (slot_d > `MAFE_SLOT_LAST)); // see R21
      fsb = fs_q && !fs_d;
      if (!slave_q) begin
        sclk_d = bit_clock_gating_pin || fsb || (gcnt_q != `MAFE_GATE_ZERO); // see R16
        if (fsb) gcnt_d = `MAFE_GATE_LOAD;
        else if (gcnt_q != `MAFE_GATE_ZERO) gcnt_d = 6'(gcnt_q - 6'h01);
      end
    end
    if (fall) begin
      sclk_d = 1'b0;
      if (phase_q != MAFE_PH_IDLE && slot_q <= `MAFE_SLOT_LAST) begin
        ish_d = {ish_q[14:0], serial_in_line}; // see R17
        full = ish_d;
        if (slot_q == `MAFE_SLOT_LAST) begin
          if (phase_q == MAFE_PH_DATA) begin
            tx_d = hc ? full : {full[15:1], 1'b0}; // see R8 see R9
            txv_d = 1'b1;
            if (hc || full[0]) pend_d = 1'b1;
          end else begin
            cw = full; // see R10
            if (!cw.rw && is_impl(cw.addr)) begin
              regs_d[cw.addr[3:0]] = (cw.data & ~ro_mask(cw.addr[3:0])) |
                (regs_q[cw.addr[3:0]] & ro_mask(cw.addr[3:0])); // see R11 see R14
            end
          end
        end
      end
    end
    // Power-down of front end or PLL drops back to the crystal
    if (!regs_d[`MAFE_R_CTRL][`MAFE_B_FRONT_END_ENABLE] || regs_d[`MAFE_R_PLL_LOCK][`MAFE_B_PWDN]) begin
      regs_d[`MAFE_R_PLL_LOCK][`MAFE_B_FRCVCO] = 1'b0; // see R3
    end
    dsoe_d = !regs_d[`MAFE_R_REV][`MAFE_B_DELAYED_SYNC_ENABLE]; // see R23
    cfg_d.slave_mode = slave_d;
    cfg_d.early_sync = early_d;
    cfg_d.front_end_enable = regs_d[`MAFE_R_CTRL][`MAFE_B_FRONT_END_ENABLE];
    cfg_d.hardware_control_bit = regs_d[`MAFE_R_TEST][`MAFE_B_HC];
    cfg_d.control_frame_position_bit = regs_d[`MAFE_R_TEST][`MAFE_B_CONTROL_FRAME_POSITION_BIT];
    cfg_d.clock_output_enable = regs_d[`MAFE_R_TEST][`MAFE_B_CKOUT];
    cfg_d.delayed_sync_enable = regs_d[`MAFE_R_REV][`MAFE_B_DELAYED_SYNC_ENABLE];
    cfg_d.use_pll_clock = regs_d[`MAFE_R_PLL_LOCK][`MAFE_B_FRCVCO];
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strap_q <= 1'b0;
      slave_q <= 1'b1;
      early_q <= 1'b1;
      div_q <= `MAFE_DIV_ZERO;
      sclk_prev_q <= 1'b0;
      fs_prev_q <= 1'b1;
      bcnt_q <= `MAFE_FRAME_LAST;
      len_q <= `MAFE_FRAME_BITS;
      phase_q <= MAFE_PH_IDLE;
      slot_q <= `MAFE_SLOT_ZERO;
      gcnt_q <= `MAFE_GATE_ZERO;
      osh_q <= `MAFE_WORD_ZERO;
      ish_q <= `MAFE_WORD_ZERO;
      tx_q <= `MAFE_WORD_ZERO;
      sout_q <= 1'b0;
      fs_q <= 1'b1;
      ds_q <= 1'b1;
      dsoe_q <= 1'b1;
      sclk_q <= 1'b0;
      txv_q <= 1'b0;
      pend_q <= 1'b0;
      regs_q <= REG_RST;
      cfg_q <= '0;
    end else begin
      strap_q <= strap_d;
      slave_q <= slave_d;
      early_q <= early_d;
      div_q <= div_d;
      sclk_prev_q <= sclk_prev_d;
      fs_prev_q <= fs_prev_d;
      bcnt_q <= bcnt_d;
      len_q <= len_d;
      phase_q <= phase_d;
      slot_q <= slot_d;
      gcnt_q <= gcnt_d;
      osh_q <= osh_d;
      ish_q <= ish_d;
      tx_q <= tx_d;
      sout_q <= sout_d;
      fs_q <= fs_d;
      ds_q <= ds_d;
      dsoe_q <= dsoe_d;
      sclk_q <= sclk_d;
      txv_q <= txv_d;
      pend_q <= pend_d;
      regs_q <= regs_d;
      cfg_q <= cfg_d;
    end
  end

  mafe_fifo #(.WIDTH(`MAFE_WORD_W), .DEPTH(`MAFE_FIFO_DEPTH)) u_rx_fifo (
    .clk(sys_clk),
    .rst_n(resetn),
    .in_data(rx_word),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  assign sclk_out = sclk_q;
  assign sclk_oe_n = slave_q; // see R18
  assign frame_sync_n = fs_q;
  assign frame_sync_oe_n = slave_q;
  assign serial_out_line = sout_q;
  assign delayed_frame_sync = ds_q;
  assign delayed_frame_sync_oe_n = dsoe_q;
  assign tx_word = tx_q;
  assign tx_valid = txv_q;
  assign cfg = cfg_q;

  // ********************************
  // Checks
  // ********************************
  logic [12:0] fc_q;
  logic seen_q, ctl_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fc_q <= 13'h0000;
      seen_q <= 1'b0;
      ctl_q <= 1'b0;
    end else begin
      fc_q <= start_data ? 13'h0000 : 13'(fc_q + 13'h0001);
      seen_q <= seen_q || start_data;
      ctl_q <= start_data ? 1'b0 : (ctl_q || start_ctrl);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_div;
    rise && !slave_q |=> !rise [*8] ##1 !rise [*8] ##1 !rise ##1 rise;
  endproperty
  a_div: assert property (p_div) else $error("bit clock period not 18"); // see R1

  property p_frame;
    start_data && !slave_q && seen_q |-> fc_q == 13'(FRAME_CYCLES - 1);
  endproperty
  a_frame: assert property (p_frame) else $error("frame period wrong"); // see R2

  property p_pll;
    (!regs_q[`MAFE_R_CTRL][`MAFE_B_FRONT_END_ENABLE] || regs_q[`MAFE_R_PLL_LOCK][`MAFE_B_PWDN]) && !fall
      |=> !cfg_q.use_pll_clock;
  endproperty
  a_pll: assert property (p_pll) else $error("PLL clock kept in power-down"); // see R3

  property p_early;
    !slave_q && early_q && $fell(fs_q) |-> ##18 $rose(fs_q);
  endproperty
  a_early: assert property (p_early) else $error("early sync not one bit"); // see R6

  property p_late;
    !slave_q && !early_q && $fell(fs_q) |-> ##288 $rose(fs_q);
  endproperty
  a_late: assert property (p_late) else $error("late sync not 16 bits"); // see R6

  property p_tx0;
    txv_q && !hc |-> !tx_q[0];
  endproperty
  a_tx0: assert property (p_tx0) else $error("request bit leaked into data"); // see R8

  property p_ctrl_hi;
    phase_q == MAFE_PH_CTRL && slot_q <= `MAFE_RD_SLOT |-> !sout_q;
  endproperty
  a_ctrl_hi: assert property (p_ctrl_hi) else $error("control reply high byte set"); // see R12

  property p_one_ctrl;
    start_ctrl |-> !ctl_q;
  endproperty
  a_one_ctrl: assert property (p_one_ctrl) else $error("second control frame"); // see R13

  property p_unimpl;
    fall && phase_q == MAFE_PH_CTRL && slot_q == `MAFE_SLOT_LAST && !is_impl(ish_q[13:7])
      |=> regs_q == $past(regs_q);
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented write stored"); // see R14

  property p_pos;
    start_ctrl && !slave_q
      |-> bcnt_d == (regs_q[`MAFE_R_TEST][`MAFE_B_CONTROL_FRAME_POSITION_BIT] ? `MAFE_POS_QUARTER : `MAFE_POS_HALF);
  endproperty
  a_pos: assert property (p_pos) else $error("control frame misplaced"); // see R15

  property p_dsoe;
    strap_q |-> dsoe_q == !regs_q[`MAFE_R_REV][`MAFE_B_DELAYED_SYNC_ENABLE];
  endproperty
  a_dsoe: assert property (p_dsoe) else $error("delayed sync enable wrong"); // see R23

endmodule

// ==== testbench/mafe_host_model.sv ====
// ************************************************
// Host serial port, late frame sync
// ************************************************
module mafe_host_model (
  input wire logic sys_clk,
  input wire logic sclk_out,
  input wire logic frame_sync_n,
  input wire logic serial_out_line,
  input wire logic [15:0] send_word,
  output logic serial_in_line,
  output logic [15:0] got_word,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sck_q = 1'b0;
  logic fs_r = 1'b1;
  logic [15:0] word_q = 16'h0000;
  logic [15:0] sh = 16'h0000;
  int slot = 16;
  logic sin_q = 1'b0;
  logic [15:0] got_q = 16'h0000;
  int frames_q = 0;
  assign serial_in_line = sin_q;
  assign got_word = got_q;
  assign frames = frames_q;
  always @(posedge sys_clk) begin
    if (sclk_out && !sck_q) begin
      if (!frame_sync_n && fs_r) begin
        slot = 0;
        word_q = send_word;
      end else if (slot < 16) begin
        slot++;
      end
      fs_r = frame_sync_n;
    end
    if (slot < 16) begin
      sin_q <= word_q[15 - slot];
    end else begin
      // Released line toggles so a stale bit never passes for data
      sin_q <= ~sin_q;
    end
    if (!sclk_out && sck_q && slot < 16) begin
      sh = {sh[14:0], serial_out_line};
      if (slot == 15) begin
        got_q <= sh;
        frames_q <= frames_q + 1;
      end
    end
    sck_q = sclk_out;
  end
endmodule

// ==== testbench/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mafe_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic ftype = 1'b0;
  logic gate = 1'b1;
  logic strap = 1'b1;
  logic pll_lock = 1'b1;
  logic rx_valid = 1'b0;
  logic hc = 1'b0;
  logic [15:0] rx_word = 16'h0000;
  logic [15:0] hw = 16'h0000;
  logic [15:0] dw = 16'h0000;
  logic [15:0] r;
  logic sclk_in, sclk_out, sclk_oe_n, fs_in, fs_n, fs_oe_n, sin, sout;
  logic dfs, dfs_oe_n, rx_ready, tx_valid;
  logic [15:0] tx_word, got;
  mafe_cfg_t cfg;
  int err_total = 0;
  int n_checks = 0;
  int frames, cyc = 0, t_f = 0, gap = 0, fs_low = 0, t_r = 0, per = 0;
  int rises = 0, rises_n = 0, t_d = 0, d_low = 0, n_tx = 0, tx0 = 0;
  logic fs_q = 1'b1, sc_q = 1'b0, d_q = 1'b1, fsx = 1'b1;
  logic [15:0] exp_q[$];

  // Pin levels from the enables; strap is the pull resistor
  assign sclk_in = sclk_oe_n ? strap : sclk_out;
  assign fs_in = fs_oe_n ? fsx : fs_n;

  mafe_serial_port dut_u (.sys_clk(sys_clk), .resetn(resetn), .frame_type_pin(ftype),
    .bit_clock_gating_pin(gate), .sclk_in(sclk_in), .sclk_out(sclk_out),
    .sclk_oe_n(sclk_oe_n), .fs_in(fs_in), .frame_sync_n(fs_n), .frame_sync_oe_n(fs_oe_n),
    .serial_in_line(sin), .serial_out_line(sout), .delayed_frame_sync(dfs),
    .delayed_frame_sync_oe_n(dfs_oe_n), .pll_lock(pll_lock), .rx_word(rx_word),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_word(tx_word), .tx_valid(tx_valid),
    .cfg(cfg));
  mafe_host_model host_u (.sys_clk(sys_clk), .sclk_out(sclk_out), .frame_sync_n(fs_n),
    .serial_out_line(sout), .send_word(hw), .serial_in_line(sin), .got_word(got),
    .frames(frames));

  always #25 sys_clk = ~sys_clk;

  // ************************************************
  // Edge timing monitor
  // ************************************************
  always @(posedge sys_clk) begin
    cyc++;
    if (fs_q && !fs_n) begin
      gap = cyc - t_f;
      t_f = cyc;
      rises_n = rises;
      rises = 0;
    end
    if (!fs_q && fs_n) fs_low = cyc - t_f;
    if (sclk_out && !sc_q) begin
      per = cyc - t_r;
      t_r = cyc;
      rises++;
    end
    if (d_q && !dfs) t_d = cyc;
    if (!d_q && dfs) d_low = cyc - t_d;
    if (tx_valid) n_tx++;
    fs_q = fs_n;
    sc_q = sclk_out;
    d_q = dfs;
  end

  // ************************************************
  // Tasks
  // ************************************************
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task xfer(input logic [15:0] w, output logic [15:0] rd);
    int n;
    int k;
    n = frames;
    hw = w;
    for (k = 0; k < 6000 && frames == n; k++) @(negedge sys_clk);
    rd = got;
    if (frames == n) begin
      err_total++;
      $display("BAD frame exp done got timeout");
      stop_test;
    end
  endtask

  task data(input logic req);
    logic [15:0] w;
    logic [15:0] e;
    dw = dw + 16'h1357;
    w = hc ? dw : {dw[15:1], req};
    e = exp_q.size() > 0 ? exp_q.pop_front() : 16'h0000;
    xfer(w, r);
    chk("rx", e, r);
    tick(2);
    chk("tx_word", hc ? w : {w[15:1], 1'b0}, tx_word);
  endtask

  task acc(input logic rw, input logic [6:0] a, input logic [7:0] d, input logic [15:0] e);
    data(1'b1);
    xfer({rw, a, d}, r);
    chk("reply", e, r);
    tick(2);
  endtask

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    tick(16);
    chk("reset outs", 16'h00ed, {cfg, sclk_oe_n, fs_n, fs_oe_n, sout, dfs, dfs_oe_n,
      tx_valid, rx_ready});
    resetn = 1'b1;
    rx_valid = 1'b1;
    for (int i = 0; i < 16; i++) begin
      rx_word = 16'ha5c0 + 16'(i);
      exp_q.push_back(rx_word);
      tick(1);
    end
    chk("rx_ready full", 16'h0000, {15'h0000, rx_ready});
    rx_valid = 1'b0;
    chk("master", 16'h0000, {cfg, 6'h00, sclk_oe_n, fs_oe_n});
    data(1'b0);
    data(1'b0);
    tick(10);
    chk("sclk period", 16'h0012, 16'(per));
    chk("frame gap", 16'h1200, 16'(gap));
    chk("late low", 16'h0120, 16'(fs_low));
    chk("rises free", 16'h0100, 16'(rises_n));
    $display("test timing done");
    acc(1'b0, 7'h03, 8'h5a, 16'h0000);
    acc(1'b0, 7'h13, 8'ha5, 16'h0000);
    acc(1'b1, 7'h03, 8'h00, 16'h005a);
    acc(1'b1, 7'h06, 8'h00, 16'h0050);
    $display("test regs done");
    acc(1'b0, 7'h00, 8'h88, 16'h0000);
    chk("front_end_enable", 16'h0001, {15'h0000, cfg.front_end_enable});
    acc(1'b0, 7'h08, 8'h01, 16'h0000);
    data(1'b0);
    data(1'b0);
    chk("xtal", 16'h0000, {15'h0000, cfg.use_pll_clock});
    acc(1'b0, 7'h0e, 8'h80, 16'h0000);
    chk("pll", 16'h0001, {15'h0000, cfg.use_pll_clock});
    acc(1'b1, 7'h0e, 8'h00, 16'h00a0);
    acc(1'b0, 7'h00, 8'h08, 16'h0000);
    chk("pwdn", 16'h0000, {15'h0000, cfg.use_pll_clock});
    $display("test clock source done");
    acc(1'b0, 7'h01, 8'h01, 16'h0000);
    hc = 1'b1;
    chk("hc", 16'h0001, {15'h0000, cfg.hardware_control_bit});
    acc(1'b0, 7'h06, 8'h08, 16'h0000);
    chk("fsd oe", 16'h0000, {15'h0000, dfs_oe_n});
    acc(1'b0, 7'h01, 8'h09, 16'h0000);
    chk("ckout", 16'h0001, {15'h0000, cfg.clock_output_enable});
    acc(1'b1, 7'h01, 8'h00, 16'h0009);
    chk("ctl half", 16'h0900, 16'(gap));
    chk("rises half", 16'h0080, 16'(rises_n));
    tick(300);
    chk("fsd start", 16'h0120, 16'(t_d - t_f));
    chk("fsd low", 16'h0120, 16'(d_low));
    $display("test chain done");
    acc(1'b0, 7'h01, 8'h0b, 16'h0000);
    gate = 1'b0;
    acc(1'b1, 7'h01, 8'h00, 16'h000b);
    chk("ctl quarter", 16'h0480, 16'(gap));
    chk("rises gated", 16'h0020, 16'(rises_n));
    $display("test position done");
    resetn = 1'b0;
    ftype = 1'b1;
    tick(16);
    resetn = 1'b1;
    tick(4700);
    chk("early low", 16'h0012, 16'(fs_low));
    chk("early cfg", 16'h0001, {15'h0000, cfg.early_sync});
    resetn = 1'b0;
    strap = 1'b0;
    tick(16);
    resetn = 1'b1;
    tick(3);
    chk("slave", 16'h0007, {13'h0000, cfg.slave_mode, sclk_oe_n, fs_oe_n});
    // External master: 96 bit clocks of 18 cycles per frame, sync low on bit 0
    tx0 = n_tx;
    for (int f = 0; f < 2; f++) begin
      for (int b = 0; b < 96; b++) begin
        fsx = (b != 0);
        strap = 1'b1;
        tick(9);
        strap = 1'b0;
        tick(9);
      end
    end
    fsx = 1'b1;
    tick(20);
    chk("slave frames", 16'h0002, 16'(n_tx - tx0));
    $display("test straps done");
    stop_test;
  end
endmodule
